// ==== include/switch_drv_consts.svh ====
// constants for the six-bit switch driver controller
`ifndef SWITCH_DRV_CONSTS_SVH
`define SWITCH_DRV_CONSTS_SVH

`define WORD_BITS        6
`define PIN_BITS         10
`define APB_ADDR_BITS    12

`define OFS_CTRL         12'h000
`define OFS_STATUS       12'h004
`define OFS_LOADS        12'h008

`define CTRL_SERIAL_ONLY 0
`define STAT_WORD_LSB    0
`define STAT_SERIAL      6
`define STAT_READY       7
`define STAT_STROBE      8
`define STAT_IN_LSB      16

`define RST_CTRL         1'b0
`define RST_WORD         6'h00
`define RST_COUNT        16'h0000

`define PUP_ZERO         6'h00
`define PUP_SEL_LOW      6'h10
`define PUP_SEL_HIGH     6'h20
`define PUP_ONES         6'h3f

`define CLK_PERIOD_NS    40
`define POWERUP_TIME_MS  200
`define POWERUP_CYCLES   ((`POWERUP_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ==== include/switch_drv_pkg.sv ====
// types shared by the switch driver controller
`include "switch_drv_consts.svh"
package switch_drv_pkg;
	typedef logic [`WORD_BITS-1:0] ctrl_word_t;
	typedef enum {PH_POWERUP, PH_RUN} phase_e;
endpackage

// ==== core/shift_word_reg.sv ====
// link-side input shift register with daisy-chain output
`timescale 1ns/10ps
`include "switch_drv_consts.svh"
module shift_word_reg (
	// link clock and reset request
	input  wire logic                      shiftClk,
	input  wire logic                      rst_n,
	// link pins
	input  wire logic                      shiftDataInput,
	input  wire logic                      loadStrobe,
	input  wire logic                      serialSelect,
	// shifted word and chain output
	output switch_drv_pkg::ctrl_word_t     shiftWord,
	output logic                           shiftDataOutput
);
	import switch_drv_pkg::*;

	logic       rstA_q, rstB_q, rstC_q, linkRstN_q, linkRstN_d;
	ctrl_word_t word_q, word_d;
	logic       shiftEn;

	// link pins are synchronous to shiftClk; only the reset request crosses in
	assign shiftEn = serialSelect && !loadStrobe && linkRstN_q;

	always_comb begin
		linkRstN_d = (rstB_q == rstC_q) ? rstC_q : linkRstN_q;
		if (!linkRstN_q)
			word_d = `RST_WORD;
		else if (shiftEn)
			word_d = {word_q[`WORD_BITS-2:0], shiftDataInput};
		else
			word_d = word_q;
	end

	// clock may stop between frames, so reset only lands on a running edge
	always_ff @(posedge shiftClk) begin
		rstA_q     <= rst_n;
		rstB_q     <= rstA_q;
		rstC_q     <= rstB_q;
		linkRstN_q <= linkRstN_d;
		word_q     <= word_d;
	end

	assign shiftWord       = word_q;
	assign shiftDataOutput = word_q[`WORD_BITS-1];

	hold_parallel_a: assert property (@(posedge shiftClk) disable iff (!linkRstN_q)
		!serialSelect |=> word_q == $past(word_q))
		else $error("shift register moved in parallel mode");
	hold_strobe_a: assert property (@(posedge shiftClk) disable iff (!linkRstN_q)
		loadStrobe |=> $stable(word_q))
		else $error("shift register moved while strobe high");
	chain_delay_a: assert property (@(posedge shiftClk) disable iff (!linkRstN_q)
		shiftEn [*6] ##1 1'b1 |-> shiftDataOutput == $past(shiftDataInput, 6))
		else $error("chain output not six edges late");
endmodule

// ==== core/six_bit_switch_driver_ctrl.sv ====
// six-bit switch driver controller: link capture, power-up, outputs, apb
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "switch_drv_consts.svh"
module six_bit_switch_driver_ctrl #(
	parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES
) (
	// system
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// apb slave
	input  wire logic [`APB_ADDR_BITS-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// serial link
	input  wire logic                      shiftClk,
	input  wire logic                      shiftDataInput,
	input  wire logic                      loadStrobe,
	input  wire logic                      serialSelect,
	output logic                           shiftDataOutput,
	// parallel and power-up pins
	input  wire switch_drv_pkg::ctrl_word_t parallelControlInputs,
	input  wire logic                      powerupSelectLow,
	input  wire logic                      powerupSelectHigh,
	// driver pairs
	output switch_drv_pkg::ctrl_word_t     trueDriverOutputs,
	output switch_drv_pkg::ctrl_word_t     complementDriverOutputs
);
	import switch_drv_pkg::*;

	localparam int CNT_W = $clog2(POWERUP_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(POWERUP_CYCLES - 1);

	// pin vector positions
	localparam int P_STROBE = `WORD_BITS;
	localparam int P_SERIAL = `WORD_BITS + 1;
	localparam int P_PUPLO  = `WORD_BITS + 2;
	localparam int P_PUPHI  = `WORD_BITS + 3;

	// power-up select decode, also used by a check
	function automatic ctrl_word_t pupDecode(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00:   pupDecode = `PUP_ZERO;
			2'b01:   pupDecode = `PUP_SEL_LOW;
			2'b10:   pupDecode = `PUP_SEL_HIGH;
			default: pupDecode = `PUP_ONES;
		endcase
	endfunction

	// register select: 0 ctrl, 1 status, 2 loads, 3 unmapped
	function automatic logic [1:0] regIndex(input logic [`APB_ADDR_BITS-1:0] a);
		case (a)
			`OFS_CTRL:   regIndex = 2'h0;
			`OFS_STATUS: regIndex = 2'h1;
			`OFS_LOADS:  regIndex = 2'h2;
			default:     regIndex = 2'h3;
		endcase
	endfunction

	// link side
	// only the strobe crosses; the word is stable while the strobe is high
	ctrl_word_t shiftWord;

	shift_word_reg linkRegs (
		.shiftClk       (shiftClk),
		.rst_n          (rst_n),
		.shiftDataInput (shiftDataInput),
		.loadStrobe     (loadStrobe),
		.serialSelect   (serialSelect),
		.shiftWord      (shiftWord),
		.shiftDataOutput(shiftDataOutput)
	);

	// pin synchronisers, three stages, change taken when stages two and three agree
	logic [`PIN_BITS-1:0] pins;
	logic [`PIN_BITS-1:0] syncA_q, syncB_q, syncC_q, filt_q, filt_d;

	assign pins = {powerupSelectHigh, powerupSelectLow, serialSelect, loadStrobe, parallelControlInputs};

	// a strobe pulse shorter than about two clocks can be missed here
	genvar gi;
	generate
		for (gi = 0; gi < `PIN_BITS; gi++) begin : g_filt
			assign filt_d[gi] = (syncB_q[gi] == syncC_q[gi]) ? syncC_q[gi] : filt_q[gi];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
			syncC_q <= '0;
			filt_q  <= '0;
		end else begin
			syncA_q <= pins;
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
			filt_q  <= filt_d;
		end
	end

	logic       strobeLvl, serialLvl, strobeRise;
	ctrl_word_t parWord, inWord;

	assign strobeLvl = filt_q[P_STROBE];
	assign serialLvl = filt_q[P_SERIAL];
	assign parWord   = filt_q[`WORD_BITS-1:0];

	// output word and power-up sequencing
	phase_e           phase_q, phase_d;
	logic [CNT_W-1:0] pupCnt_q, pupCnt_d;
	logic             strobePrev_q, strobePrev_d;
	ctrl_word_t       outWord_q, outWord_d, compl_q, compl_d;
	ctrl_word_t       capWord_q, capWord_d;
	logic             loadEvent;

	assign strobeRise = strobeLvl && !strobePrev_q;

	// parallel mode makes the input register follow the parallel pins;
	// serial mode shows the captured copy, the live shift word belongs to the link clock
	assign inWord = serialLvl ? capWord_q : parWord;

	always_comb begin
		phase_d      = phase_q;
		pupCnt_d     = pupCnt_q;
		outWord_d    = outWord_q;
		capWord_d    = capWord_q;
		strobePrev_d = strobeLvl;
		loadEvent    = 1'b0;
		case (phase_q)
			PH_POWERUP: begin
				// the pins are watched for the whole wait; the last view is kept
				if (strobeLvl)
					outWord_d = parWord;
				else
					outWord_d = pupDecode(filt_q[P_PUPHI], filt_q[P_PUPLO]);
				if (pupCnt_q == CNT_LAST)
					phase_d = PH_RUN;
				else
					pupCnt_d = pupCnt_q + 1'b1;
			end
			PH_RUN: begin
				if (serialLvl) begin
					// take the link word only at the rise: shifting may restart
					// before the synchronised strobe has fallen
					if (strobeRise) begin
						capWord_d = shiftWord;
						outWord_d = shiftWord;
						loadEvent = 1'b1;
					end
				end else if (strobeLvl) begin
					outWord_d = parWord;
					loadEvent = strobeRise;
				end
				// strobe low: nothing above fires, so the word holds
			end
			default: begin
				phase_d = PH_POWERUP;
				pupCnt_d = '0;
			end
		endcase
		compl_d = ~outWord_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_q      <= PH_POWERUP;
			pupCnt_q     <= '0;
			outWord_q    <= `RST_WORD;
			compl_q      <= ~`RST_WORD;
			capWord_q    <= `RST_WORD;
			strobePrev_q <= 1'b0;
		end else begin
			phase_q      <= phase_d;
			pupCnt_q     <= pupCnt_d;
			outWord_q    <= outWord_d;
			compl_q      <= compl_d;
			capWord_q    <= capWord_d;
			strobePrev_q <= strobePrev_d;
		end
	end

	assign trueDriverOutputs       = outWord_q;
	assign complementDriverOutputs = compl_q;

	// apb registers
	logic        serialOnly_q, serialOnly_d;
	logic [15:0] loads_q, loads_d;
	logic [31:0] rdata_q, rdata_d;
	logic        setup, access, countIt;
	logic [1:0]  idx;

	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign idx     = regIndex(paddr);
	assign countIt = loadEvent && (serialLvl || !serialOnly_q);

	always_comb begin
		serialOnly_d = serialOnly_q;
		rdata_d      = rdata_q;
		// counting wins over a clear in the same cycle
		loads_d      = ((access && pwrite && idx == 2'h2) ? `RST_COUNT : loads_q) + {15'h0000, countIt};
		if (access && pwrite && idx == 2'h0)
			serialOnly_d = pwdata[`CTRL_SERIAL_ONLY];
		// status is a snapshot taken in the setup cycle
		if (setup) begin
			rdata_d = 32'h0000_0000;
			case (idx)
				2'h0: rdata_d[`CTRL_SERIAL_ONLY] = serialOnly_q;
				2'h1: begin
					rdata_d[`STAT_WORD_LSB +: `WORD_BITS] = outWord_q;
					rdata_d[`STAT_SERIAL]                 = serialLvl;
					rdata_d[`STAT_READY]                  = (phase_q == PH_RUN);
					rdata_d[`STAT_STROBE]                 = strobeLvl;
					rdata_d[`STAT_IN_LSB +: `WORD_BITS]   = inWord;
				end
				2'h2: rdata_d[15:0] = loads_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serialOnly_q <= `RST_CTRL;
			loads_q      <= `RST_COUNT;
			rdata_q      <= 32'h0000_0000;
		end else begin
			serialOnly_q <= serialOnly_d;
			loads_q      <= loads_d;
			rdata_q      <= rdata_d;
		end
	end

	// zero-wait slave; read data was prepared in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = access && (idx == 2'h3);
	assign prdata  = rdata_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	output_hold_a: assert property (
		phase_q == PH_RUN && !strobeLvl |=> outWord_q == $past(outWord_q))
		else $error("outputs moved with strobe low");
	pair_complement_a: assert property (
		complementDriverOutputs == ~trueDriverOutputs)
		else $error("driver pair not complementary");
	direct_follow_a: assert property (
		phase_q == PH_RUN && !serialLvl && strobeLvl |=> trueDriverOutputs == $past(parWord))
		else $error("direct mode outputs do not follow inputs");
	serial_load_a: assert property (
		phase_q == PH_RUN && serialLvl && strobeRise |=> trueDriverOutputs == $past(shiftWord))
		else $error("serial word not loaded on strobe rise");
	serial_ignore_a: assert property (
		phase_q == PH_RUN && !serialLvl && strobeLvl && shiftWord != parWord |=>
			trueDriverOutputs != $past(shiftWord))
		else $error("shift word leaked into parallel mode");
	pup_table_a: assert property (
		phase_q == PH_POWERUP && !strobeLvl |=>
			trueDriverOutputs == $past(pupDecode(filt_q[P_PUPHI], filt_q[P_PUPLO])))
		else $error("power-up table output wrong");
	pup_inputs_a: assert property (
		phase_q == PH_POWERUP && strobeLvl |=> trueDriverOutputs == $past(parWord))
		else $error("power-up inputs not applied");
	pup_latch_a: assert property (
		phase_q == PH_POWERUP && pupCnt_q == CNT_LAST |=> phase_q == PH_RUN ##1 phase_q == PH_RUN)
		else $error("power-up wait length wrong");
	bad_addr_a: assert property (
		access && idx == 2'h3 |-> pslverr && pready && prdata == 32'h0000_0000)
		else $error("unmapped access not flagged");
endmodule

// ==== dv/host_link_model.sv ====
// host-side model of the three-wire link driving the controller
`timescale 1ns/10ps
module host_link_model #(
	parameter int BIT_NS = 100
) (
	// link pins toward the device
	output logic shiftClk,
	output logic shiftDataInput,
	output logic loadStrobe
);
	import switch_drv_pkg::*;

	// clock stands still low outside frames
	initial begin
		shiftClk = 1'b0;
		shiftDataInput = 1'b0;
		loadStrobe = 1'b0;
	end

	// one bit per BIT_NS, never above the top bit rate
	task automatic clockBit(input logic b);
		shiftDataInput = b;
		#(BIT_NS / 2) shiftClk = ~shiftClk;
		#(BIT_NS / 2) shiftClk = ~shiftClk;
		// hold time over: data no longer valid
		shiftDataInput = ~b;
	endtask

	// msb first, exactly six bits
	task automatic shiftWord(input ctrl_word_t w);
		for (int i = 5; i >= 0; i--) begin
			clockBit(w[i]);
		end
	endtask

	task automatic runClocks(input int n);
		repeat (n) clockBit(shiftDataInput);
	endtask

	// spacing kept on both sides of every pulse
	task automatic pulse();
		#630 loadStrobe <= 1'b1;
		#200 loadStrobe <= 1'b0;
		#630;
	endtask

	task automatic setStrobe(input logic level);
		loadStrobe <= level;
	endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the six-bit switch driver controller
`timescale 1ns/10ps
`include "switch_drv_consts.svh"
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb;
	import switch_drv_pkg::*;
	localparam int PUP = 20;
	typedef struct { logic [1:0] mode; ctrl_word_t word; } row_s;
	logic                      clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [`APB_ADDR_BITS-1:0] paddr;
	logic [31:0]               pwdata, prdata, rd;
	logic                      serialSelect, powerupSelectLow, powerupSelectHigh;
	logic                      shiftClk, shiftDataInput, loadStrobe, shiftDataOutput;
	ctrl_word_t                parallelControlInputs, trueDriverOutputs, complementDriverOutputs, prev;
	int                        miscompares = 0;
	int                        nTests = 0;
	// mode 0 serial, 1 latched parallel, 2 direct parallel
	row_s rows[8] = '{'{2'd0, 6'h20}, '{2'd0, 6'h01}, '{2'd0, 6'h15}, '{2'd1, 6'h3f},
		'{2'd1, 6'h00}, '{2'd2, 6'h2a}, '{2'd0, 6'h3e}, '{2'd1, 6'h1c}};

	six_bit_switch_driver_ctrl #(.POWERUP_CYCLES(PUP)) i_six_bit_switch_driver_ctrl (
		.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .shiftClk(shiftClk),
		.shiftDataInput(shiftDataInput), .loadStrobe(loadStrobe), .serialSelect(serialSelect),
		.shiftDataOutput(shiftDataOutput), .parallelControlInputs(parallelControlInputs),
		.powerupSelectLow(powerupSelectLow), .powerupSelectHigh(powerupSelectHigh),
		.trueDriverOutputs(trueDriverOutputs), .complementDriverOutputs(complementDriverOutputs));
	host_link_model i_host_link_model (.shiftClk(shiftClk), .shiftDataInput(shiftDataInput),
		.loadStrobe(loadStrobe));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask

	function automatic ctrl_word_t pupWord(input logic [1:0] s);
		case (s)
			2'b00: return 6'h00;
			2'b01: return 6'h10;
			2'b10: return 6'h20;
			default: return 6'h3f;
		endcase
	endfunction

	task automatic checkOut(input string what, input ctrl_word_t w);
		`CHK(what, w, trueDriverOutputs)
		`CHK("complement pair", ~w, complementDriverOutputs)
	endtask

	// setup then access, held until pready seen high
	task automatic apb(input logic wr, input logic [`APB_ADDR_BITS-1:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// no wait count assumed; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// link domain needs its own clock edges while reset is low and again after release
	task automatic doReset(input logic [1:0] sel, input logic le, input ctrl_word_t par);
		rst_n <= 1'b0;
		powerupSelectHigh <= sel[1];
		powerupSelectLow <= sel[0];
		parallelControlInputs <= par;
		serialSelect <= ~le;
		i_host_link_model.setStrobe(le);
		waitClk(6);
		i_host_link_model.runClocks(6);
		@(posedge clk);
		rst_n <= 1'b1;
		i_host_link_model.runClocks(6);
		waitClk(PUP + 10);
	endtask

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		serialSelect = 1'b1;
		powerupSelectLow = 1'b0;
		powerupSelectHigh = 1'b0;
		parallelControlInputs = '0;
		@(posedge clk);
		for (int s = 0; s < 4; s++) begin
			doReset(s[1:0], 1'b0, 6'h3f);
			checkOut("power-up select", pupWord(s[1:0]));
		end
		doReset(2'b00, 1'b1, 6'h2a);
		checkOut("power-up inputs", 6'h2a);
		i_host_link_model.setStrobe(1'b0);
		waitClk(8);
		prev = 6'h2a;
		foreach (rows[i]) begin
			serialSelect <= (rows[i].mode == 2'd0);
			parallelControlInputs <= rows[i].word;
			waitClk(8);
			checkOut("held output", prev);
			if (rows[i].mode == 2'd0) begin
				i_host_link_model.shiftWord(rows[i].word);
				`CHK("chain output", rows[i].word[5], shiftDataOutput)
			end
			if (rows[i].mode == 2'd2)
				i_host_link_model.setStrobe(1'b1);
			else
				i_host_link_model.pulse();
			waitClk(8);
			checkOut("loaded word", rows[i].word);
			prev = rows[i].word;
			if (rows[i].mode == 2'd2) begin
				parallelControlInputs <= ~rows[i].word;
				waitClk(8);
				checkOut("direct follow", ~rows[i].word);
				i_host_link_model.setStrobe(1'b0);
				prev = ~rows[i].word;
			end
		end
		// shifting while the strobe is high must not reach the outputs
		serialSelect <= 1'b1;
		waitClk(4);
		i_host_link_model.shiftWord(6'h0f);
		i_host_link_model.pulse();
		i_host_link_model.setStrobe(1'b1);
		i_host_link_model.shiftWord(6'h30);
		i_host_link_model.setStrobe(1'b0);
		i_host_link_model.pulse();
		waitClk(8);
		checkOut("masked shift", 6'h0f);
		apb(1'b1, `OFS_CTRL, 32'h1);
		apb(1'b0, `OFS_CTRL, 32'h0);
		`CHK("ctrl register", 32'h1, rd)
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK("status word", 32'h0f, rd & 32'h3f)
		// eleven loads since the last reset: eight rows and three masked-shift strobes
		apb(1'b0, `OFS_LOADS, 32'h0);
		`CHK("load total", 32'h0000_000b, rd)
		apb(1'b1, `OFS_LOADS, 32'h0);
		apb(1'b0, `OFS_LOADS, 32'h0);
		`CHK("load count", 32'h0, rd)
		// one latched and one serial load per pass; serial-only counts just the serial one
		for (int k = 1; k >= 0; k--) begin
			apb(1'b1, `OFS_CTRL, 32'(k));
			apb(1'b1, `OFS_LOADS, 32'h0);
			serialSelect <= 1'b0;
			waitClk(8);
			i_host_link_model.pulse();
			waitClk(8);
			checkOut("latched word", 6'h1c);
			serialSelect <= 1'b1;
			waitClk(8);
			i_host_link_model.shiftWord(6'h2d);
			i_host_link_model.pulse();
			waitClk(8);
			checkOut("serial word", 6'h2d);
			apb(1'b0, `OFS_LOADS, 32'h0);
			`CHK("load count", 32'(2 - k), rd)
			apb(1'b0, `OFS_STATUS, 32'h0);
			`CHK("status word", 32'h002d_00ed, rd)
			apb(1'b0, `OFS_LOADS + 12'(4 + 4 * k), 32'h0);
			`CHK("unmapped error", 1'b1, err)
			`CHK("unmapped data", 32'h0, rd)
		end
		conclude();
	end

	// far beyond the expected run of some fifty microseconds
	initial begin
		#500000;
		miscompares++;
		conclude();
	end
endmodule
